// [common/ubrg_pkg.sv]
/*
  shared constants for the serial baud rate generator: source select codes,
  field widths, operating mode codes and fixed division factors.
  assumes a single 20 MHz master clock.
*/
package ubrg_pkg;
  localparam int CD_W = 16;
  localparam int FP_W = 3;
  localparam int SRC_W = 2;
  localparam int MODE_W = 2;
  localparam logic [SRC_W-1:0] SRC_MAIN = 2'h0;
  localparam logic [SRC_W-1:0] SRC_DIV = 2'h1;
  localparam logic [SRC_W-1:0] SRC_PIN = 2'h3;
  localparam logic [MODE_W-1:0] MODE_ASYNC = 2'h0;
  localparam logic [MODE_W-1:0] MODE_SYNC = 2'h1;
  localparam logic [MODE_W-1:0] MODE_SPI_MST = 2'h2;
  localparam logic [MODE_W-1:0] MODE_SPI_SLV = 2'h3;
  localparam int MAIN_DIV = 8;
  localparam logic [3:0] MAIN_DIV_LAST = 4'(MAIN_DIV - 1);
  localparam logic [4:0] OVS16_LAST = 5'h0F;
  localparam logic [4:0] OVS8_LAST = 5'h07;
  localparam logic [FP_W-1:0] FP_ZERO = 3'h0;
  localparam logic [CD_W-1:0] CD_OFF = 16'h0000;
  localparam logic [CD_W-1:0] CD_BYPASS = 16'h0001;
  localparam int CLK_HZ = 20000000;
endpackage

// [common/ubrg_tick_if.sv]
/*
  carries the selected source tick and divisor settings from the top module
  into the divider core. assumes one clock domain.
*/
`timescale 1ns/10ps
interface ubrg_tick_if;
  logic src_tick;
  logic [ubrg_pkg::CD_W-1:0] divisor;
  logic [ubrg_pkg::FP_W-1:0] frac;
  logic frac_en;
  logic restart;
  logic samp_tick;
  modport core
  (
    input src_tick,
    input divisor,
    input frac,
    input frac_en,
    input restart,
    output samp_tick
  );
  modport top
  (
    output src_tick,
    output divisor,
    output frac,
    output frac_en,
    output restart,
    input samp_tick
  );
endinterface

// [src/ubrg_divider.sv]
/*
  16-bit divisor with optional eighth-step fractional extension.
  counts source ticks and emits one sampling tick per divisor period.
  assumes src_tick is a one-cycle enable on the master clock.
*/
`timescale 1ns/10ps
module ubrg_divider
(
  input wire logic CLK_I,
  input wire logic SRST_I,
  ubrg_tick_if.core tk
);
  logic [ubrg_pkg::CD_W-1:0] cnt_ff;
  logic [ubrg_pkg::CD_W-1:0] nxt_cnt;
  logic [ubrg_pkg::FP_W:0] acc_ff;
  logic [ubrg_pkg::FP_W:0] nxt_acc;
  logic stretch_ff;
  logic nxt_stretch;
  logic samp_ff;
  logic nxt_samp;
  wire logic dis = (tk.divisor == ubrg_pkg::CD_OFF);
  wire logic byp = (tk.divisor == ubrg_pkg::CD_BYPASS) && !tk.frac_en;
  wire logic last = (cnt_ff >= tk.divisor - ubrg_pkg::CD_BYPASS);
  wire logic end_per = tk.src_tick && last && !stretch_ff;
  // fractional accumulator: each carry adds one extra source tick to the period
  wire logic [ubrg_pkg::FP_W:0] acc_sum = {1'b0, acc_ff[ubrg_pkg::FP_W-1:0]} + {1'b0, tk.frac};
  wire logic carry = tk.frac_en && acc_sum[ubrg_pkg::FP_W];

  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_acc = acc_ff;
    nxt_stretch = stretch_ff;
    nxt_samp = 1'b0;
    if (tk.restart || dis)
    begin
      nxt_cnt = '0;
      nxt_acc = '0;
      nxt_stretch = 1'b0;
    end
    else if (byp)
      nxt_samp = tk.src_tick;
    else if (tk.src_tick)
    begin
      if (stretch_ff)
      begin
        nxt_stretch = 1'b0;
        nxt_samp = 1'b1;
      end
      else if (last)
      begin
        nxt_cnt = '0;
        nxt_acc = tk.frac_en ? acc_sum : '0;
        nxt_stretch = carry;
        nxt_samp = !carry;
      end
      else
        nxt_cnt = cnt_ff + ubrg_pkg::CD_BYPASS;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      cnt_ff <= '0;
      acc_ff <= '0;
      stretch_ff <= 1'b0;
      samp_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      acc_ff <= nxt_acc;
      stretch_ff <= nxt_stretch;
      samp_ff <= nxt_samp;
    end
  end

  assign tk.samp_tick = samp_ff;
endmodule

// [src/ubrg_top.sv]
/*
  baud rate generator of a synchronous/asynchronous serial port: source
  select, divisor, oversampling and spi pin roles. one 20 MHz clock; the
  serial clock pin is asynchronous and is synchronised here.
*/
// Functional notes
// - source is master clock, master clock divided by eight, or serial clock pin
// - selected source divided by a 16-bit divisor
// - divisor zero stops baud ticks, except in sync and SPI modes with pin source
// - divisor one bypasses the divider unless fraction active
// - async: divided clock is sampling tick, divided again by 16 or 8
// - async bit rate is source over 8*(2-over)*divisor
// - fraction only active in ordinary asynchronous mode
// - clear-to-send active low; slave select input in SPI slave mode
// - request-to-send active low; slave select output in SPI master mode
// - SPI master: tx is MOSI, rx MISO; slave: tx MISO, rx MOSI
// - gated clock resumes from held state
// - configuration writes accepted while block clock disabled
// - sync and SPI bit rate is source over divisor, no oversampling, except with pin source (pin clock undivided)
// - sync mode with pin source takes pin clock undivided
`timescale 1ns/10ps
module ubrg_top
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic CLK_EN_I,
  // configuration
  input wire logic [ubrg_pkg::SRC_W-1:0] BAUD_SOURCE_SELECT_I,
  input wire logic [ubrg_pkg::CD_W-1:0] CLOCK_DIVISOR_I,
  input wire logic [ubrg_pkg::FP_W-1:0] FRACTION_PART_I,
  input wire logic OVER_I,
  input wire logic [ubrg_pkg::MODE_W-1:0] MODE_I,
  input wire logic CFG_WR_I,
  // serial clock pin
  input wire logic SCK_I,
  // transceiver side
  input wire logic TX_DATA_I,
  input wire logic TX_OE_I,
  input wire logic RTS_REQ_I,
  input wire logic SPI_SEL_I,
  output logic RX_DATA_O,
  output logic CTS_ACTIVE_O,
  output logic SAMPLE_TICK_O,
  output logic BAUD_TICK_O,
  // pins
  input wire logic RXD_I,
  input wire logic CTS_N_I,
  output logic TXD_O,
  output logic TXD_OE_O,
  output logic RTS_N_O
);
  ubrg_tick_if tk ();

  logic [ubrg_pkg::SRC_W-1:0] src_ff;
  logic [ubrg_pkg::CD_W-1:0] cd_ff;
  logic [ubrg_pkg::FP_W-1:0] fp_ff;
  logic over_ff;
  logic [ubrg_pkg::MODE_W-1:0] mode_ff;
  logic pend_ff;
  logic restart_ff;
  logic [2:0] sck_sync_ff;
  logic [1:0] rxd_sync_ff;
  logic [1:0] cts_sync_ff;
  logic [3:0] mdiv_ff;
  logic [4:0] ovs_ff;
  logic [4:0] nxt_ovs;
  logic baud_ff;
  logic nxt_baud;
  logic samp_ff;

  wire logic is_async = (mode_ff == ubrg_pkg::MODE_ASYNC);
  wire logic is_spi_mst = (mode_ff == ubrg_pkg::MODE_SPI_MST);
  wire logic is_spi_slv = (mode_ff == ubrg_pkg::MODE_SPI_SLV);
  wire logic pin_direct = !is_async && (src_ff == ubrg_pkg::SRC_PIN);
  wire logic sck_rise = sck_sync_ff[1] && !sck_sync_ff[2];
  wire logic mdiv_tick = (mdiv_ff == ubrg_pkg::MAIN_DIV_LAST);
  wire logic [4:0] ovs_last = over_ff ? ubrg_pkg::OVS8_LAST : ubrg_pkg::OVS16_LAST;
  wire logic src_tick;

  // source select
  assign src_tick = (src_ff == ubrg_pkg::SRC_MAIN) ? 1'b1 :
                    (src_ff == ubrg_pkg::SRC_DIV) ? mdiv_tick :
                    (src_ff == ubrg_pkg::SRC_PIN) ? sck_rise : 1'b0;

  assign tk.src_tick = CLK_EN_I && src_tick;
  assign tk.divisor = cd_ff;
  assign tk.frac = fp_ff;
  assign tk.frac_en = is_async && (fp_ff != ubrg_pkg::FP_ZERO);
  assign tk.restart = restart_ff;

  ubrg_divider u_div
  (
    .CLK_I(CLK_I),
    .SRST_I(SRST_I),
    .tk(tk)
  );

  // config capture runs regardless of the clock enable
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      src_ff <= ubrg_pkg::SRC_MAIN;
      cd_ff <= ubrg_pkg::CD_OFF;
      fp_ff <= ubrg_pkg::FP_ZERO;
      over_ff <= 1'b0;
      mode_ff <= ubrg_pkg::MODE_ASYNC;
      pend_ff <= 1'b0;
      restart_ff <= 1'b0;
    end
    else
    begin
      restart_ff <= 1'b0;
      if (CFG_WR_I)
      begin
        src_ff <= BAUD_SOURCE_SELECT_I;
        cd_ff <= CLOCK_DIVISOR_I;
        fp_ff <= FRACTION_PART_I;
        over_ff <= OVER_I;
        mode_ff <= MODE_I;
        pend_ff <= (CLOCK_DIVISOR_I != cd_ff) || (FRACTION_PART_I != fp_ff);
      end
      else if (pend_ff && CLK_EN_I)
      begin
        pend_ff <= 1'b0;
        restart_ff <= 1'b1;
      end
    end
  end

  // pin synchronisers
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      sck_sync_ff <= '0;
      rxd_sync_ff <= 2'h3;
      cts_sync_ff <= 2'h3;
    end
    else
    begin
      sck_sync_ff <= {sck_sync_ff[1:0], SCK_I};
      rxd_sync_ff <= {rxd_sync_ff[0], RXD_I};
      cts_sync_ff <= {cts_sync_ff[0], CTS_N_I};
    end
  end

  // divided main clock prescaler and oversampling stage
  always_comb
  begin
    nxt_ovs = ovs_ff;
    nxt_baud = 1'b0;
    if (restart_ff || (cd_ff == ubrg_pkg::CD_OFF))
      nxt_ovs = '0;
    // a tick launched on the last enabled edge still counts, so gating drops no period
    else if (tk.samp_tick)
    begin
      if (!is_async)
        nxt_baud = 1'b1;
      else if (ovs_ff >= ovs_last)
      begin
        nxt_ovs = '0;
        nxt_baud = 1'b1;
      end
      else
        nxt_ovs = ovs_ff + 5'h01;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      mdiv_ff <= '0;
      ovs_ff <= '0;
      baud_ff <= 1'b0;
      samp_ff <= 1'b0;
    end
    else if (pin_direct)
    begin
      baud_ff <= CLK_EN_I && sck_rise;
      samp_ff <= CLK_EN_I && sck_rise;
      ovs_ff <= '0;
    end
    else
    begin
      if (CLK_EN_I)
        mdiv_ff <= mdiv_tick ? 4'h0 : mdiv_ff + 4'h1;
      ovs_ff <= nxt_ovs;
      baud_ff <= nxt_baud;
      samp_ff <= tk.samp_tick && is_async;
    end
  end

  // pin roles
  assign TXD_O = TX_DATA_I;
  assign TXD_OE_O = is_spi_slv ? (TX_OE_I && !cts_sync_ff[1]) : TX_OE_I;
  assign RX_DATA_O = rxd_sync_ff[1];
  assign CTS_ACTIVE_O = !cts_sync_ff[1];
  assign RTS_N_O = is_spi_mst ? !SPI_SEL_I : !RTS_REQ_I;
  assign SAMPLE_TICK_O = samp_ff;
  assign BAUD_TICK_O = baud_ff;
endmodule

// [bench/ubrg_remote.sv]
/* far-side serial device: serial clock, receive data, clear-to-send.
   assumes a 50 ns master clock. */
`timescale 1ns/10ps
module ubrg_remote
(
  // from bench
  input wire logic run_i,
  input wire logic rx_bit_i,
  input wire logic cts_low_i,
  // pins
  output logic sck_o,
  output logic rxd_o,
  output logic cts_n_o
);
  // phases of four master periods, clock held low when idle
  initial
  begin
    sck_o = 1'b0;
    forever #200 sck_o = run_i ? ~sck_o : 1'b0;
  end
  // bench divisors give exact rates and no interrupt line exists here
  assign rxd_o = rx_bit_i;
  assign cts_n_o = !cts_low_i;
endmodule

// [bench/ubrg_top_asserts.sv]
/* port assertions for ubrg_top.
   assumes bind into ubrg_top, one clock. */
`timescale 1ns/10ps
module ubrg_chk
(
  // inputs
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic CLK_EN_I,
  input wire logic [1:0] BAUD_SOURCE_SELECT_I,
  input wire logic [15:0] CLOCK_DIVISOR_I,
  input wire logic [2:0] FRACTION_PART_I,
  input wire logic [1:0] MODE_I,
  input wire logic CFG_WR_I,
  input wire logic SCK_I,
  input wire logic TX_DATA_I,
  input wire logic RTS_REQ_I,
  input wire logic SPI_SEL_I,
  input wire logic CTS_N_I,
  // outputs
  input wire logic SAMPLE_TICK_O,
  input wire logic BAUD_TICK_O,
  input wire logic TXD_O,
  input wire logic TXD_OE_O,
  input wire logic RTS_N_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  logic [22:0] cfg_ff;
  logic [3:0] age_ff;
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      cfg_ff <= 23'h000000;
    else if (CFG_WR_I)
      cfg_ff <= {BAUD_SOURCE_SELECT_I, CLOCK_DIVISOR_I, FRACTION_PART_I, MODE_I};
    if (SRST_I || CFG_WR_I)
      age_ff <= 4'h0;
    else if (age_ff != 4'hF)
      age_ff <= age_ff + 4'h1;
  end
  // settled once no write for fifteen cycles
  wire logic ok_w = age_ff == 4'hF;
  wire logic as_w = ok_w && cfg_ff[1:0] == ubrg_pkg::MODE_ASYNC;
  wire logic d2_w = as_w && cfg_ff[22:2] == {ubrg_pkg::SRC_MAIN, 16'h0002, ubrg_pkg::FP_ZERO};
  wire logic pin_w = ok_w && cfg_ff[22:21] == ubrg_pkg::SRC_PIN && cfg_ff[1:0] == ubrg_pkg::MODE_SYNC;
  wire logic mst_w = cfg_ff[1:0] == ubrg_pkg::MODE_SPI_MST;
  wire logic slv_w = cfg_ff[1:0] == ubrg_pkg::MODE_SPI_SLV;
  chk_txd_follow: assert property (TXD_O == TX_DATA_I)
    else $error("txd");
  chk_rts_role: assert property (RTS_N_O == (mst_w ? !SPI_SEL_I : !RTS_REQ_I))
    else $error("rts");
  chk_slave_sel: assert property ((slv_w && CTS_N_I) [*4] |-> !TXD_OE_O)
    else $error("slave select");
  chk_gate_hold: assert property ((!CLK_EN_I) [*3] |-> !SAMPLE_TICK_O && !BAUD_TICK_O)
    else $error("gated tick");
  chk_div_zero: assert property (as_w && cfg_ff[20:5] == ubrg_pkg::CD_OFF |-> !SAMPLE_TICK_O && !BAUD_TICK_O)
    else $error("divisor zero");
  chk_baud_gap: assert property (as_w && BAUD_TICK_O |=> (!BAUD_TICK_O || !as_w) [*7])
    else $error("baud gap");
  chk_samp_div2: assert property ($past(CLK_EN_I) && CLK_EN_I && SAMPLE_TICK_O && d2_w ##1 CLK_EN_I [*2]
    |-> SAMPLE_TICK_O) else $error("sample spacing");
  chk_pin_direct: assert property (pin_w && CLK_EN_I && $rose(SCK_I) |-> ##[2:4] BAUD_TICK_O)
    else $error("pin clock");
endmodule
bind ubrg_top ubrg_chk chk_u
(
  .CLK_I(CLK_I),
  .SRST_I(SRST_I),
  .CLK_EN_I(CLK_EN_I),
  .BAUD_SOURCE_SELECT_I(BAUD_SOURCE_SELECT_I),
  .CLOCK_DIVISOR_I(CLOCK_DIVISOR_I),
  .FRACTION_PART_I(FRACTION_PART_I),
  .MODE_I(MODE_I),
  .CFG_WR_I(CFG_WR_I),
  .SCK_I(SCK_I),
  .TX_DATA_I(TX_DATA_I),
  .RTS_REQ_I(RTS_REQ_I),
  .SPI_SEL_I(SPI_SEL_I),
  .CTS_N_I(CTS_N_I),
  .SAMPLE_TICK_O(SAMPLE_TICK_O),
  .BAUD_TICK_O(BAUD_TICK_O),
  .TXD_O(TXD_O),
  .TXD_OE_O(TXD_OE_O),
  .RTS_N_O(RTS_N_O)
);

// [bench/tb_top.sv]
/* bench for ubrg_top: tick counts per setting and pin roles.
   assumes ubrg_remote on the serial pins. */
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0, srst = 1'b1, en = 1'b1, cfg_wr = 1'b0, over = 1'b0;
  logic tx_data = 1'b0, tx_oe = 1'b0, rts_req = 1'b0, spi_sel = 1'b0;
  logic sck_run = 1'b0, rx_bit = 1'b0, cts_low = 1'b0;
  logic [1:0] src = 2'h0, mode = 2'h0;
  logic [15:0] cd = 16'h0000, a, b;
  logic [2:0] fp = 3'h0;
  logic sck, rxd, cts_n, rx_data, cts_act, samp, baud, txd, txd_oe, rts_n;
  int errors = 0, n_compared = 0;
  ubrg_top dut_u
  (
    .CLK_I(clk), .SRST_I(srst), .CLK_EN_I(en), .BAUD_SOURCE_SELECT_I(src), .CLOCK_DIVISOR_I(cd),
    .FRACTION_PART_I(fp), .OVER_I(over), .MODE_I(mode), .CFG_WR_I(cfg_wr), .SCK_I(sck), .TX_DATA_I(tx_data),
    .TX_OE_I(tx_oe), .RTS_REQ_I(rts_req), .SPI_SEL_I(spi_sel), .RX_DATA_O(rx_data), .CTS_ACTIVE_O(cts_act),
    .SAMPLE_TICK_O(samp), .BAUD_TICK_O(baud), .RXD_I(rxd), .CTS_N_I(cts_n), .TXD_O(txd), .TXD_OE_O(txd_oe),
    .RTS_N_O(rts_n)
  );
  ubrg_remote peer_u
  (
    .run_i(sck_run), .rx_bit_i(rx_bit), .cts_low_i(cts_low), .sck_o(sck), .rxd_o(rxd), .cts_n_o(cts_n)
  );
  initial
  begin
    forever #25 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic cfg(input logic [1:0] s, input logic [15:0] dv, input logic [2:0] f, input logic o, input logic [1:0] m);
    {src, cd, fp, over, mode, cfg_wr} = {s, dv, f, o, m, 1'b1};
    step(1);
    cfg_wr = 1'b0;
    step(20);
  endtask
  // adds the ticks of n cycles to the totals
  task automatic count(input int n, ref logic [15:0] ns, ref logic [15:0] nb);
    repeat (n)
    begin
      step(1);
      ns = ns + 16'(samp);
      nb = nb + 16'(baud);
    end
  endtask
  task automatic run(input logic [1:0] s, input logic [15:0] dv, input logic [2:0] f, input logic o,
                     input logic [1:0] m, input logic [15:0] es, input logic [15:0] eb);
    cfg(s, dv, f, o, m);
    {a, b} = 32'h00000000;
    count(320, a, b);
    check("samp", a, es);
    check("baud", b, eb);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    step(16);
    srst = 1'b0;
    run(ubrg_pkg::SRC_MAIN, 16'h0000, 3'h0, 1'b1, ubrg_pkg::MODE_ASYNC, 16'h0000, 16'h0000);
    run(ubrg_pkg::SRC_MAIN, 16'h0002, 3'h0, 1'b1, ubrg_pkg::MODE_ASYNC, 16'h00A0, 16'h0014);
    run(ubrg_pkg::SRC_MAIN, 16'h0002, 3'h0, 1'b0, ubrg_pkg::MODE_ASYNC, 16'h00A0, 16'h000A);
    run(ubrg_pkg::SRC_MAIN, 16'h0001, 3'h0, 1'b1, ubrg_pkg::MODE_ASYNC, 16'h0140, 16'h0028);
    run(ubrg_pkg::SRC_DIV, 16'h0001, 3'h0, 1'b1, ubrg_pkg::MODE_ASYNC, 16'h0028, 16'h0005);
    run(2'h2, 16'h0002, 3'h0, 1'b1, ubrg_pkg::MODE_ASYNC, 16'h0000, 16'h0000);
    run(ubrg_pkg::SRC_MAIN, 16'h0002, 3'h4, 1'b1, ubrg_pkg::MODE_ASYNC, 16'h0080, 16'h0010);
    run(ubrg_pkg::SRC_MAIN, 16'h0004, 3'h4, 1'b0, ubrg_pkg::MODE_SYNC, 16'h0000, 16'h0050);
    sck_run = 1'b1;
    run(ubrg_pkg::SRC_PIN, 16'h0005, 3'h0, 1'b0, ubrg_pkg::MODE_SYNC, 16'h0028, 16'h0028);
    sck_run = 1'b0;
    cfg(ubrg_pkg::SRC_MAIN, 16'h0002, 3'h0, 1'b1, ubrg_pkg::MODE_ASYNC);
    {a, b} = 32'h00000000;
    count(100, a, b);
    en = 1'b0;
    count(60, a, b);
    en = 1'b1;
    count(220, a, b);
    check("gated samp", a, 16'h00A0);
    check("gated baud", b, 16'h0014);
    en = 1'b0;
    cfg(ubrg_pkg::SRC_MAIN, 16'h0001, 3'h0, 1'b1, ubrg_pkg::MODE_ASYNC);
    en = 1'b1;
    step(20);
    {a, b} = 32'h00000000;
    count(320, a, b);
    check("late cfg", a, 16'h0140);
    check("late cfg baud", b, 16'h0028);
    cfg(ubrg_pkg::SRC_MAIN, 16'h0000, 3'h0, 1'b0, ubrg_pkg::MODE_SPI_MST);
    {spi_sel, tx_data, rx_bit} = 3'h7;
    step(4);
    check("rts", 16'(rts_n), 16'h0000);
    check("txd", 16'(txd), 16'h0001);
    check("rxd", 16'(rx_data), 16'h0001);
    {spi_sel, tx_data} = 2'h0;
    step(1);
    check("rts", 16'(rts_n), 16'h0001);
    cfg(ubrg_pkg::SRC_MAIN, 16'h0000, 3'h0, 1'b0, ubrg_pkg::MODE_SPI_SLV);
    {tx_oe, cts_low} = 2'h3;
    step(5);
    check("cts", 16'(cts_act), 16'h0001);
    check("oe", 16'(txd_oe), 16'h0001);
    cts_low = 1'b0;
    step(5);
    check("oe", 16'(txd_oe), 16'h0000);
    cfg(ubrg_pkg::SRC_MAIN, 16'h0000, 3'h0, 1'b0, ubrg_pkg::MODE_ASYNC);
    rts_req = 1'b1;
    step(1);
    check("rts", 16'(rts_n), 16'h0000);
    report_and_stop();
  end
endmodule
